//--- rcao_pkg.sv
/*
 * Shared constants and carrier types of the real-time clock calibration,
 * pin output and alarm block.
 * Assumes word-aligned AXI4-Lite accesses with 32-bit data.
 */
package rcao_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_CAL     = 8'h00;
  localparam logic [7:0] OFF_PAD     = 8'h04;
  localparam logic [7:0] OFF_ALM     = 8'h08;
  localparam logic [7:0] OFF_MIN_SEC_VALUE  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h18;

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CAL_ON_BIT     = 15;
  localparam int CAL_UNLOCK_BIT = 13;
  localparam int CAL_HALF_BIT   = 11;
  localparam int CAL_OE_BIT     = 10;
  localparam int PAD_SEL_LSB    = 1;
  localparam int PAD_BUF_BIT    = 0;
  localparam int ALM_ON_BIT     = 15;
  localparam int ALM_WRAP_BIT   = 14;
  localparam int ALM_MASK_LSB   = 10;
  localparam int ALM_PTR_LSB    = 8;
  localparam int IRQ_W          = 2;
  localparam int IRQ_ALARM      = 0;
  localparam int IRQ_MINUTE     = 1;

  //////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [7:0]  TRIM_RST   = 8'h00;
  localparam logic [15:0] MIN_SEC_VALUE_RST = 16'h0000;
  localparam logic [7:0]  CNT_RST    = 8'h00;
  localparam logic [7:0]  CNT_WRAP   = 8'hFF;
  localparam logic [1:0]  PIN_ALARM  = 2'h0;
  localparam logic [1:0]  PIN_SEC    = 2'h1;
  localparam logic [1:0]  PIN_SRC    = 2'h2;
  localparam logic [3:0]  MASK_HALF  = 4'h0;
  localparam logic [3:0]  MASK_SEC   = 4'h1;
  localparam logic [3:0]  MASK_10S   = 4'h2;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // Timing counts, in source clock pulses and seconds
  localparam int         SEC_PULSES_DEF = 32768;
  localparam logic [5:0] SEC_LAST       = 6'h3B;
  localparam logic [5:0] TEN_MOD        = 6'h0A;
  localparam logic [5:0] TEN_LAST       = 6'h09;
  localparam int         TRIM_SHIFT     = 2;

  //////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } rcao_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rcao_axi_rsp_t;

  typedef struct packed {
    logic [9:0] pend;
    logic       neg;
  } rcao_trim_state_t;

  typedef struct packed {
    logic        cal_on;
    logic        cal_unlock;
    logic        cal_oe;
    logic [7:0]  trim;
    logic        half;
    logic [1:0]  pad_sel;
    logic        pad_buf;
    logic        alm_on;
    logic        alm_wrap;
    logic [3:0]  alm_mask;
    logic [1:0]  alm_ptr;
    logic [7:0]  alm_cnt;
    logic [15:0] min_sec;
    logic [15:0] sub_cnt;
    logic [5:0]  sec_cnt;
    logic        min_evt;
    logic        alarm_pulse;
    logic [1:0]  irq_st;
    logic [1:0]  irq_en;
    logic        src_q;
    logic        pin;
    logic        aw_got;
    logic        w_got;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rcao_state_t;

endpackage : rcao_pkg

//--- rcao_drift_trim.sv
/*
 * Drift trim: adds or swallows source clock pulses once per minute.
 * Assumes ref_clk is far faster than the source clock, so inserted
 * pulses fit between real ones.
 */
`timescale 1ns/1ps
module rcao_drift_trim (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic       src_edge,
  input  wire logic       minute_tick,
  input  wire logic [7:0] trim_code,
  output logic            count_adv
);

  rcao_pkg::rcao_trim_state_t st_reg;
  rcao_pkg::rcao_trim_state_t st_next;
  logic [7:0]                 mag;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    mag       = trim_code[7] ? 8'(-trim_code) : trim_code;
    st_next   = st_reg;
    count_adv = src_edge;
    if (!run) begin
      st_next.pend = '0;
    end else if (minute_tick) begin
      // Four pulses per step, both signs
      st_next.neg  = trim_code[7];
      st_next.pend = 10'(mag) << rcao_pkg::TRIM_SHIFT; // see [R1]
    end else if (st_reg.pend != 10'h000) begin
      if (st_reg.neg && src_edge) begin
        count_adv    = 1'b0; // see [R3] see [R4]
        st_next.pend = st_reg.pend - 10'h001;
      end else if (!st_reg.neg && !src_edge) begin
        count_adv    = 1'b1; // see [R2]
        st_next.pend = st_reg.pend - 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_trim_load_pos: assert property ( // see [R1]
    run && minute_tick && !trim_code[7]
      |=> st_reg.pend == {$past(trim_code), 2'b00})
    else $error("positive trim not loaded as four per step");
  a_trim_add_pulse: assert property ( // see [R2]
    run && !minute_tick && !st_reg.neg && st_reg.pend != 10'h000
      && !src_edge |-> count_adv)
    else $error("positive trim did not insert a pulse");
  a_trim_drop_pulse: assert property ( // see [R3]
    run && !minute_tick && st_reg.neg && st_reg.pend != 10'h000
      && src_edge |-> !count_adv)
    else $error("negative trim did not swallow a pulse");
  a_trim_max_neg: assert property ( // see [R4]
    run && minute_tick && trim_code == 8'h80
      |=> st_reg.neg && st_reg.pend == 10'h200)
    else $error("most negative trim not 512 pulses");

endmodule : rcao_drift_trim

//--- rcao_top.sv
/*
 * Real-time clock calibration, pin output select and alarm repeat logic,
 * reached over an AXI4-Lite slave port.
 * Assumes reset_n is the power-on reset and sys_reset_n a synchronous
 * system reset; oscillator inputs are synchronous to ref_clk.
 */
// How it works
// [R1] Positive trim adds four pulses per step
// [R2] Smallest positive trim inserts four pulses per minute
// [R3] Trim of minus one removes four pulses
// [R4] Most negative trim removes 512 pulses
// [R5] Calibration register cleared only by power-on
// [R6] Module on written only while unlocked
// [R7] Half-second flag cleared by low seconds write
// [R8] Select 01 drives one-second clock to pin
// [R9] Select 00 drives alarm pulse; reset value
// [R10] Select 10 drives selected raw source clock
// [R11] Software never programs select to 11
// [R12] Alarm turns off when count zero, no wrap
// [R13] Wrap set: counter rolls 00h to FFh
`timescale 1ns/1ps
module rcao_top #(
  parameter int SEC_PULSES = rcao_pkg::SEC_PULSES_DEF
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  input  wire logic                    sys_reset_n,
  input  wire logic                    internal_low_power_osc,
  input  wire logic                    secondary_osc,
  input  wire logic                    rtc_osc_select,
  input  wire rcao_pkg::rcao_axi_req_t axi_req,
  output rcao_pkg::rcao_axi_rsp_t      axi_rsp,
  output logic                         clock_calendar_output,
  output logic                         parallel_port_buffer_select,
  output logic                         irq
);

  localparam logic [15:0] SUB_LAST  = 16'(SEC_PULSES - 1);
  localparam logic [15:0] HALF_LAST = 16'(SEC_PULSES / 2 - 1);

  rcao_pkg::rcao_state_t st_reg;
  rcao_pkg::rcao_state_t st_next;
  logic                  src_clk;
  logic                  src_edge;
  logic                  count_adv;
  logic                  run;
  logic                  sec_tick;
  logic                  half_tick;
  logic                  minute_tick;
  logic                  alm_evt;
  logic                  wr_go;
  logic                  rd_go;
  logic [7:0]            wr_off;
  logic [7:0]            rd_off;
  logic                  wr_hi_ok;
  logic                  rd_hi_ok;
  logic [15:0]           rd_val;
  logic                  rd_ok;
  logic [1:0]            irq_clr;

  //////////////////////////////////////////////////////////////////////////
  // Source clock and pulse counting
  assign src_clk  = rtc_osc_select ? secondary_osc
                                   : internal_low_power_osc;
  assign src_edge = src_clk && !st_reg.src_q;
  assign run      = st_reg.cal_on;

  rcao_drift_trim u_trim (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .run         (run),
    .src_edge    (src_edge),
    .minute_tick (st_reg.min_evt),
    .trim_code   (st_reg.trim),
    .count_adv   (count_adv)
  );

  assign sec_tick    = run && count_adv && st_reg.sub_cnt == SUB_LAST;
  assign half_tick   = run && count_adv && st_reg.sub_cnt == HALF_LAST;
  assign minute_tick = sec_tick && st_reg.sec_cnt == rcao_pkg::SEC_LAST;

  always_comb begin
    alm_evt = 1'b0;
    if (st_reg.alm_on) begin
      case (st_reg.alm_mask)
        rcao_pkg::MASK_HALF: alm_evt = half_tick || sec_tick;
        rcao_pkg::MASK_SEC:  alm_evt = sec_tick;
        rcao_pkg::MASK_10S:  alm_evt = sec_tick
          && (st_reg.sec_cnt % rcao_pkg::TEN_MOD) == rcao_pkg::TEN_LAST;
        default:             alm_evt = minute_tick;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign wr_go    = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign rd_go    = axi_req.arvalid && !st_reg.rvalid;
  assign wr_off   = st_reg.waddr[7:0];
  assign rd_off   = axi_req.araddr[7:0];
  assign wr_hi_ok = st_reg.waddr[31:8] == 24'h000000;
  assign rd_hi_ok = axi_req.araddr[31:8] == 24'h000000;

  always_comb begin
    rd_val = 16'h0000;
    rd_ok  = rd_hi_ok;
    case (rd_off)
      rcao_pkg::OFF_CAL: begin
        rd_val[rcao_pkg::CAL_ON_BIT]     = st_reg.cal_on;
        rd_val[rcao_pkg::CAL_UNLOCK_BIT] = st_reg.cal_unlock;
        rd_val[rcao_pkg::CAL_HALF_BIT]   = st_reg.half;
        rd_val[rcao_pkg::CAL_OE_BIT]     = st_reg.cal_oe;
        rd_val[7:0]                      = st_reg.trim;
      end
      rcao_pkg::OFF_PAD: begin
        rd_val[rcao_pkg::PAD_SEL_LSB +: 2] = st_reg.pad_sel;
        rd_val[rcao_pkg::PAD_BUF_BIT]      = st_reg.pad_buf;
      end
      rcao_pkg::OFF_ALM: begin
        rd_val[rcao_pkg::ALM_ON_BIT]        = st_reg.alm_on;
        rd_val[rcao_pkg::ALM_WRAP_BIT]      = st_reg.alm_wrap;
        rd_val[rcao_pkg::ALM_MASK_LSB +: 4] = st_reg.alm_mask;
        rd_val[rcao_pkg::ALM_PTR_LSB +: 2]  = st_reg.alm_ptr;
        rd_val[7:0]                         = st_reg.alm_cnt;
      end
      rcao_pkg::OFF_MIN_SEC_VALUE:  rd_val = st_reg.min_sec;
      rcao_pkg::OFF_IRQ_ST:  rd_val[1:0] = st_reg.irq_st;
      rcao_pkg::OFF_IRQ_CLR: rd_val = 16'h0000;
      rcao_pkg::OFF_IRQ_EN:  rd_val[1:0] = st_reg.irq_en;
      default:               rd_ok = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next         = st_reg;
    irq_clr         = 2'h0;
    st_next.src_q   = src_clk;
    st_next.min_evt = minute_tick;

    // Bus channels
    if (axi_req.awvalid && !st_reg.aw_got) begin
      st_next.aw_got = 1'b1;
      st_next.waddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_reg.w_got) begin
      st_next.w_got = 1'b1;
      st_next.wdata = axi_req.wdata;
      st_next.wstrb = axi_req.wstrb;
    end
    if (st_reg.bvalid && axi_req.bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && axi_req.rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = {16'h0000, rd_val};
      st_next.rresp  = rd_ok ? rcao_pkg::RESP_OKAY : rcao_pkg::RESP_SLVERR;
    end

    // Register writes
    if (wr_go) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = rcao_pkg::RESP_OKAY;
      if (!wr_hi_ok) begin
        st_next.bresp = rcao_pkg::RESP_SLVERR;
      end else begin
        case (wr_off)
          rcao_pkg::OFF_CAL: begin
            if (st_reg.wstrb[1]) begin
              if (st_reg.cal_unlock) begin
                st_next.cal_on =
                  st_reg.wdata[rcao_pkg::CAL_ON_BIT]; // see [R6]
              end
              st_next.cal_unlock = st_reg.wdata[rcao_pkg::CAL_UNLOCK_BIT];
              st_next.cal_oe     = st_reg.wdata[rcao_pkg::CAL_OE_BIT];
            end
            if (st_reg.wstrb[0]) begin
              st_next.trim = st_reg.wdata[7:0];
            end
          end
          rcao_pkg::OFF_PAD: begin
            if (st_reg.wstrb[0]) begin
              st_next.pad_sel = st_reg.wdata[rcao_pkg::PAD_SEL_LSB +: 2];
              st_next.pad_buf = st_reg.wdata[rcao_pkg::PAD_BUF_BIT];
            end
          end
          rcao_pkg::OFF_ALM: begin
            if (st_reg.wstrb[1]) begin
              st_next.alm_on   = st_reg.wdata[rcao_pkg::ALM_ON_BIT];
              st_next.alm_wrap = st_reg.wdata[rcao_pkg::ALM_WRAP_BIT];
              st_next.alm_mask = st_reg.wdata[rcao_pkg::ALM_MASK_LSB +: 4];
              st_next.alm_ptr  = st_reg.wdata[rcao_pkg::ALM_PTR_LSB +: 2];
            end
            if (st_reg.wstrb[0]) begin
              st_next.alm_cnt = st_reg.wdata[7:0];
            end
          end
          rcao_pkg::OFF_MIN_SEC_VALUE: begin
            if (st_reg.wstrb[0]) begin
              st_next.half = 1'b0; // see [R7]
              if (st_reg.cal_unlock) begin
                st_next.min_sec[7:0] = st_reg.wdata[7:0];
              end
            end
            if (st_reg.wstrb[1] && st_reg.cal_unlock) begin
              st_next.min_sec[15:8] = st_reg.wdata[15:8];
            end
          end
          rcao_pkg::OFF_IRQ_ST: begin
            // Status is read-only; the write is ignored
          end
          rcao_pkg::OFF_IRQ_CLR: begin
            if (st_reg.wstrb[0]) begin
              irq_clr = st_reg.wdata[1:0];
            end
          end
          rcao_pkg::OFF_IRQ_EN: begin
            if (st_reg.wstrb[0]) begin
              st_next.irq_en = st_reg.wdata[1:0];
            end
          end
          default: st_next.bresp = rcao_pkg::RESP_SLVERR;
        endcase
      end
    end

    // Second and half-second timing; hardware set wins over a clear
    if (run && count_adv) begin
      st_next.sub_cnt = sec_tick ? 16'h0000 : st_reg.sub_cnt + 16'h0001;
    end
    if (half_tick) begin
      st_next.half = 1'b1;
    end
    if (sec_tick) begin
      st_next.half    = 1'b0;
      st_next.sec_cnt = minute_tick ? 6'h00 : st_reg.sec_cnt + 6'h01;
    end

    // Alarm repeat handling
    st_next.alarm_pulse = alm_evt;
    if (alm_evt) begin
      if (st_reg.alm_cnt != rcao_pkg::CNT_RST) begin
        st_next.alm_cnt = st_reg.alm_cnt - 8'h01;
      end else if (st_reg.alm_wrap) begin
        st_next.alm_cnt = rcao_pkg::CNT_WRAP; // see [R13]
      end else begin
        st_next.alm_on = 1'b0; // see [R12]
      end
    end

    // Sticky interrupt status
    st_next.irq_st = st_reg.irq_st & ~irq_clr;
    if (alm_evt) begin
      st_next.irq_st[rcao_pkg::IRQ_ALARM] = 1'b1;
    end
    if (minute_tick) begin
      st_next.irq_st[rcao_pkg::IRQ_MINUTE] = 1'b1;
    end

    // Clock output pin; code 11 is reserved and drives low
    st_next.pin = 1'b0;
    if (st_reg.cal_oe) begin
      case (st_reg.pad_sel)
        rcao_pkg::PIN_ALARM: st_next.pin = st_reg.alarm_pulse; // see [R9]
        rcao_pkg::PIN_SEC:   st_next.pin = st_reg.half; // see [R8]
        rcao_pkg::PIN_SRC:   st_next.pin = st_reg.src_q; // see [R10]
        default:             st_next.pin = 1'b0; // see [R11]
      endcase
    end

    // System reset spares the calibration register
    if (!sys_reset_n) begin
      st_next            = '0; // see [R5]
      st_next.cal_on     = st_reg.cal_on;
      st_next.cal_unlock = st_reg.cal_unlock;
      st_next.cal_oe     = st_reg.cal_oe;
      st_next.trim       = st_reg.trim;
      st_next.half       = st_reg.half;
      st_next.src_q      = src_clk;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign axi_rsp.awready = !st_reg.aw_got;
  assign axi_rsp.wready  = !st_reg.w_got;
  assign axi_rsp.bvalid  = st_reg.bvalid;
  assign axi_rsp.bresp   = st_reg.bresp;
  assign axi_rsp.arready = !st_reg.rvalid;
  assign axi_rsp.rvalid  = st_reg.rvalid;
  assign axi_rsp.rdata   = st_reg.rdata;
  assign axi_rsp.rresp   = st_reg.rresp;

  assign clock_calendar_output       = st_reg.pin;
  assign parallel_port_buffer_select = st_reg.pad_buf;
  assign irq                         = |(st_reg.irq_st & st_reg.irq_en);

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_cal_write;
    wr_go && wr_hi_ok && wr_off == rcao_pkg::OFF_CAL && st_reg.wstrb[1];
  endsequence

  sequence s_low_sec_write;
    wr_go && wr_hi_ok && wr_off == rcao_pkg::OFF_MIN_SEC_VALUE
      && st_reg.wstrb[0];
  endsequence

  a_cal_por_only: assert property ( // see [R5]
    !sys_reset_n |=> st_reg.trim == $past(st_reg.trim)
      && st_reg.cal_on == $past(st_reg.cal_on))
    else $error("calibration changed by system reset");
  a_on_locked: assert property ( // see [R6]
    s_cal_write ##0 !st_reg.cal_unlock && sys_reset_n
      |=> $stable(st_reg.cal_on))
    else $error("module on changed while locked");
  a_on_unlocked: assert property ( // see [R6]
    s_cal_write ##0 st_reg.cal_unlock && sys_reset_n
      |=> st_reg.cal_on == $past(st_reg.wdata[15]))
    else $error("module on not written while unlocked");
  a_half_cleared: assert property ( // see [R7]
    s_low_sec_write ##0 !half_tick && sys_reset_n |=> !st_reg.half)
    else $error("half-second flag not cleared by write");
  a_pin_second: assert property ( // see [R8]
    st_reg.cal_oe && st_reg.pad_sel == rcao_pkg::PIN_SEC && sys_reset_n
      |=> clock_calendar_output == $past(st_reg.half))
    else $error("pin not driven by one-second clock");
  a_pin_alarm: assert property ( // see [R9]
    alm_evt && sys_reset_n ##1 st_reg.cal_oe
      && st_reg.pad_sel == rcao_pkg::PIN_ALARM && sys_reset_n
      |=> clock_calendar_output)
    else $error("alarm pulse missing on pin");
  a_pin_source: assert property ( // see [R10]
    st_reg.cal_oe && st_reg.pad_sel == rcao_pkg::PIN_SRC && sys_reset_n
      |=> clock_calendar_output == $past(src_clk, 2))
    else $error("pin not driven by source clock");
  a_alarm_auto_off: assert property ( // see [R12]
    alm_evt && st_reg.alm_cnt == 8'h00 && !st_reg.alm_wrap
      |=> !st_reg.alm_on)
    else $error("alarm not turned off at count zero");
  a_repeat_wrap: assert property ( // see [R13]
    alm_evt && st_reg.alm_cnt == 8'h00 && st_reg.alm_wrap && sys_reset_n
      |=> st_reg.alm_cnt == 8'hFF && st_reg.alm_on)
    else $error("repeat count did not wrap to FFh");

endmodule : rcao_top

//--- tb_rcao_top.sv
/*
 * Self-checking testbench of rcao_top: AXI4-Lite register tasks, trim,
 * alarm repeat, half flag and pin output scenarios.
 * Assumes the design carries its own assertions; SEC_PULSES is cut to 16.
 */
`timescale 1ns/1ps
module tb_rcao_top;
  logic                    ref_clk;
  logic                    reset_n;
  logic                    sys_reset_n;
  logic                    osc;
  logic                    sec_osc;
  logic                    osc_sel;
  logic                    osc_run;
  logic                    pin;
  logic                    pbuf;
  logic                    irq;
  logic [1:0]              div;
  logic [31:0]             rd;
  logic [1:0]              rs;
  rcao_pkg::rcao_axi_req_t req;
  rcao_pkg::rcao_axi_rsp_t rsp;
  int                      edges = 0;
  int                      cyc = 0;
  int                      err_total = 0;
  int                      checks_done = 0;
  int                      n;
  logic [7:0]              codes [5] = '{8'h00, 8'h01, 8'h7F, 8'hFF, 8'h80};

  rcao_top #(.SEC_PULSES(16)) rcao_top_inst (
    .ref_clk                     (ref_clk),
    .reset_n                     (reset_n),
    .sys_reset_n                 (sys_reset_n),
    .internal_low_power_osc      (osc),
    .secondary_osc               (sec_osc),
    .rtc_osc_select              (osc_sel),
    .axi_req                     (req),
    .axi_rsp                     (rsp),
    .clock_calendar_output       (pin),
    .parallel_port_buffer_select (pbuf),
    .irq                         (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Source clock: one rising edge every four cycles, counted here
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (osc_run) begin
      div <= div + 2'h1;
      if (div[0]) osc <= ~osc;
      if (div[0] && !osc) edges <= edges + 1;
    end
    if (cyc == 80000) begin
      err_total++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // A wait that runs out is a mismatch and ends the run
  task automatic lim(input string nm, input bit ok);
    if (!ok) begin
      err_total++;
      $display("FAIL %s expected answer seen timeout", nm);
      end_of_test();
    end
  endtask : lim

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    bit done = 1'b0;
    @(posedge ref_clk);
    req.awaddr <= {24'h000000, a};
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    repeat (100) begin
      @(posedge ref_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
        break;
      end
    end
    lim("write answer", done);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    bit done = 1'b0;
    @(posedge ref_clk);
    req.araddr <= {24'h000000, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    repeat (100) begin
      @(posedge ref_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
        break;
      end
    end
    lim("read answer", done);
  endtask : axr

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] m, input logic [31:0] e);
    axr(a);
    chk(nm, e, rd & m);
  endtask : rc

  task automatic wirq();
    bit seen = 1'b0;
    repeat (20000) begin
      @(posedge ref_clk);
      if (irq === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    lim("interrupt", seen);
  endtask : wirq

  // Source edges between two minute boundaries; both ends are taken
  // as irq rises, so the latency cancels
  task automatic meas(output int cnt);
    int e0;
    axw(rcao_pkg::OFF_IRQ_CLR, 32'h00000002, 4'hF);
    wirq();
    e0 = edges;
    axw(rcao_pkg::OFF_IRQ_CLR, 32'h00000002, 4'hF);
    wirq();
    cnt = edges - e0;
  endtask : meas

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    sys_reset_n = 1'b1;
    osc = 1'b0;
    sec_osc = 1'b0;
    osc_sel = 1'b0;
    osc_run = 1'b0;
    div = 2'h0;
    req = '0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rc("calib", rcao_pkg::OFF_CAL, 32'hFFFFFFFF, 32'h0);
    rc("pad", rcao_pkg::OFF_PAD, 32'hFFFFFFFF, 32'h0);
    rc("alarm", rcao_pkg::OFF_ALM, 32'hFFFFFFFF, 32'h0);
    axr(8'h40);
    chk("unmapped resp", {30'h0, rcao_pkg::RESP_SLVERR}, {30'h0, rs});
    $display("test reset done");
    axw(rcao_pkg::OFF_CAL, 32'h00008000, 4'h3);
    rc("locked on", rcao_pkg::OFF_CAL, 32'hF7FF, 32'h0);
    axw(rcao_pkg::OFF_CAL, 32'h00002000, 4'h3);
    axw(rcao_pkg::OFF_CAL, 32'h0000A400, 4'h3);
    rc("unlocked on", rcao_pkg::OFF_CAL, 32'hF7FF, 32'hA400);
    axw(rcao_pkg::OFF_PAD, 32'h00000001, 4'h3);
    repeat (3) @(posedge ref_clk);
    chk("buffer select", 32'h1, {31'h0, pbuf});
    sys_reset_n <= 1'b0;
    @(posedge ref_clk);
    sys_reset_n <= 1'b1;
    rc("calib kept", rcao_pkg::OFF_CAL, 32'hF7FF, 32'hA400);
    rc("pad cleared", rcao_pkg::OFF_PAD, 32'hFFFF, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("buffer cleared", 32'h0, {31'h0, pbuf});
    $display("test lock and reset done");
    osc_run <= 1'b1;
    axw(rcao_pkg::OFF_IRQ_EN, 32'h00000002, 4'hF);
    foreach (codes[i]) begin
      axw(rcao_pkg::OFF_CAL, {16'h0, 8'hA4, codes[i]}, 4'h3);
      meas(n);
      chk("minute edges", 32'(960 - 4 * int'($signed(codes[i]))),
          32'(n));
    end
    $display("test trim done");
    axw(rcao_pkg::OFF_IRQ_EN, 32'h00000001, 4'hF);
    axw(rcao_pkg::OFF_IRQ_CLR, 32'h00000003, 4'hF);
    axw(rcao_pkg::OFF_ALM, 32'h00008000, 4'h3);
    wirq();
    rc("alarm stop", rcao_pkg::OFF_ALM, 32'hFFFF, 32'h0);
    axw(rcao_pkg::OFF_IRQ_CLR, 32'h00000001, 4'hF);
    chk("irq cleared", 32'h0, {31'h0, irq});
    axw(rcao_pkg::OFF_ALM, 32'h0000C400, 4'h3);
    wirq();
    rc("alarm wrap", rcao_pkg::OFF_ALM, 32'hFFFF, 32'hC4FF);
    axw(rcao_pkg::OFF_ALM, 32'h00000000, 4'h3);
    $display("test alarm done");
    repeat (200) begin
      axr(rcao_pkg::OFF_CAL);
      if (rd[11]) break;
    end
    chk("half flag set", 32'h0800, rd & 32'h0800);
    osc_run <= 1'b0;
    axw(rcao_pkg::OFF_PAD, 32'h00000002, 4'h3);
    repeat (4) @(posedge ref_clk);
    chk("pin seconds high", 32'h1, {31'h0, pin});
    axw(rcao_pkg::OFF_MIN_SEC_VALUE, 32'h00000000, 4'h1);
    rc("half flag", rcao_pkg::OFF_CAL, 32'h0800, 32'h0);
    repeat (4) @(posedge ref_clk);
    chk("pin seconds low", 32'h0, {31'h0, pin});
    osc_sel <= 1'b1;
    sec_osc <= 1'b1;
    axw(rcao_pkg::OFF_PAD, 32'h00000004, 4'h3);
    repeat (4) @(posedge ref_clk);
    chk("pin source high", 32'h1, {31'h0, pin});
    sec_osc <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("pin source low", 32'h0, {31'h0, pin});
    $display("test pin done");
    end_of_test();
  end
endmodule : tb_rcao_top
